//--- testbench/config_memory_readback_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module config_memory_readback_tb_top;
   typedef struct packed {
      logic       cap;
      logic       stall;
      logic [6:0] st;
   } crbk_row_s;
   logic        clk = 1'b0, rst = 1'b1, start = 1'b0, abrt = 1'b0, rdy = 1'b1;
   logic        done = 1'b0, cap = 1'b0, cfg_we = 1'b0, ram_we = 1'b0, ram_d = 1'b0;
   logic        usr = 1'b1;
   logic [1:0]  cfg_f = 2'h0;
   logic [2:0]  ram_a = 3'h0;
   logic [6:0]  st = 7'h00;
   logic [15:0] cfg_w = 16'h0000;
   wire         ready, busy, w_last, w_valid;
   wire  [15:0] word;
   int          err_count = 0, check_count = 0;
   logic [15:0] img [4] = '{16'h3c5a, 16'h9e21, 16'h47b8, 16'hd06c};
   crbk_row_s   rows [4] = '{'{1'b1, 1'b0, 7'h55}, '{1'b1, 1'b1, 7'h0f},
                             '{1'b0, 1'b0, 7'h7f}, '{1'b1, 1'b0, 7'h00}};
   crbk_link_if i_crbk_link_if ();
   wire  [5:0]  idle_v = {i_crbk_link_if.readout_serial_out, i_crbk_link_if.read_in_progress,
                          i_crbk_link_if.readout_trigger, ready, w_valid, busy};
   crbk_dev i_crbk_dev (
      .i_sys_clk(clk), .i_reset(rst), .i_ce(1'b1), .lnk(i_crbk_link_if.dev),
      .i_opt_capture(cap), .i_opt_abort(1'b1), .i_opt_user_clk(usr),
      .i_config_clock(i_crbk_link_if.readout_shift_clock),
      .i_done(done), .i_cfg_we(cfg_we), .i_cfg_frame(cfg_f), .i_cfg_word(cfg_w),
      .i_ram_we(ram_we), .i_ram_addr(ram_a), .i_ram_data(ram_d), .i_logic_cell_out(st[6:3]),
      .i_io_cell_out_ff(st[2]), .i_io_input_first(st[1]), .i_io_input_second(st[0]),
      .o_ready(ready));
   crbk_ctl i_crbk_ctl (
      .i_sys_clk(clk), .i_reset(rst), .i_ce(1'b1), .lnk(i_crbk_link_if.ctl), .i_start(start),
      .i_abort(abrt), .o_busy(busy), .o_word(word), .o_word_last(w_last),
      .o_word_valid(w_valid), .i_word_ready(rdy));
   crbk_chk i_crbk_chk (
      .i_sys_clk(clk), .i_reset(rst), .readout_trigger(i_crbk_link_if.readout_trigger),
      .readout_shift_clock(i_crbk_link_if.readout_shift_clock),
      .readout_serial_out(i_crbk_link_if.readout_serial_out),
      .read_in_progress(i_crbk_link_if.read_in_progress));
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
      check_count++;
      if (s !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wrap_up();
      if (err_count == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Abort the controller and wait for it to settle back to idle
   task automatic stop_run();
      int n;
      n = 0;
      abrt <= 1'b1;
      while (busy !== 1'b0) begin
         @(posedge clk);
         n++;
         if (n == 3000) begin
            err_count++;
            wrap_up();
         end
      end
      abrt <= 1'b0;
      @(posedge clk);
      chk("rip after stop", 16'h0000, {15'h0000, i_crbk_link_if.read_in_progress});
   endtask
   task automatic run(input crbk_row_s r);
      logic [15:0] e [4];
      logic [10:0] c;
      logic        fb;
      int          n, k;
      c = 11'h000;
      n = 0;
      k = 0;
      e[0] = img[0] | 16'hc000;
      e[1] = r.cap ? {img[1][15], ~r.st, img[1][7:0]} : img[1];
      e[2] = img[2];
      e[3] = img[3] | 16'h0007;
      for (int i = 0; i < 64; i++) begin
         fb = c[10] ^ e[i / 16][15 - i % 16];
         c = {c[9:0], 1'b0} ^ (fb ? crbk_pkg::CRC_POLY : 11'h000);
      end
      cap <= r.cap;
      st <= r.st;
      rdy <= !r.stall;
      @(posedge clk);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      while (k < 5 || busy !== 1'b0) begin
         @(negedge clk);
         if (w_valid === 1'b1 && rdy === 1'b1 && k < 5) begin
            chk("word", k < 4 ? e[k] : {5'h00, c}, k < 4 ? word : {5'h00, word[10:0]});
            chk("last", {15'h0000, k == 4}, {15'h0000, w_last});
            k++;
         end
         @(posedge clk);
         n++;
         // Late input change must not reach the capture already taken
         if (n == 300)
            st <= ~r.st;
         if (n == 2000)
            rdy <= 1'b1;
         if (n == 8000) begin
            err_count++;
            wrap_up();
         end
      end
   endtask
   initial begin
      forever #4 clk = ~clk;
   end
   initial begin
      repeat (19) @(posedge clk);
      chk("reset", 16'h0020, {10'h000, idle_v});
      @(posedge clk);
      rst <= 1'b0;
      for (int f = 0; f < 4; f++) begin
         cfg_we <= 1'b1;
         cfg_f <= 2'(f);
         cfg_w <= img[f];
         @(posedge clk);
      end
      cfg_we <= 1'b0;
      ram_we <= 1'b1;
      ram_a <= 3'h5;
      ram_d <= ~img[2][5];
      @(posedge clk);
      ram_we <= 1'b0;
      img[2][5] = ~img[2][5];
      done <= 1'b1;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      chk("ready early", 16'h0000, {15'h0000, ready});
      repeat (200) @(posedge clk);
      chk("refused", 16'h0001, {14'h0000, i_crbk_link_if.read_in_progress, ready});
      stop_run();
      foreach (rows[r])
         run(rows[r]);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      repeat (600) @(posedge clk);
      stop_run();
      // Rearmed run on the configuration clock pin instead of the user clock
      usr <= 1'b0;
      run(rows[0]);
      wrap_up();
   end
endmodule
`default_nettype wire

//--- testbench/crbk_chk.sv
`timescale 1ns/1ps
`default_nettype none
module crbk_chk (
   // Link and its clock domain
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic readout_trigger,
   input wire logic readout_shift_clock,
   input wire logic readout_serial_out,
   input wire logic read_in_progress
);
   logic       clk_q;
   logic [4:0] since_q;
   logic [6:0] cnt_q;
   // Sample on the falling link edge, half a period after the shift settles
   wire        rise    = readout_shift_clock && !clk_q;
   wire        smp     = clk_q && !readout_shift_clock && read_in_progress;
   wire  [6:0] fbit    = (cnt_q - 7'h06) % 7'h15;
   wire        body    = cnt_q >= 7'h06 && cnt_q < 7'h5a;
   wire  [4:0] since_d = rise ? 5'h00 : (since_q == 5'h1f ? since_q : since_q + 5'h01);
   wire  [6:0] cnt_d   = !read_in_progress ? 7'h00 : cnt_q + {6'h00, smp};
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         clk_q <= 1'b0;
         since_q <= 5'h1f;
         cnt_q <= 7'h00;
      end else begin
         clk_q <= readout_shift_clock;
         since_q <= since_d;
         cnt_q <= cnt_d;
      end
   end
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);
   AST_RIP_RISE: assert property ($rose(read_in_progress) |-> readout_trigger && since_q <= 5'h07)
      else $error("rip rose away from a shift clock rise");
   AST_ONE_SHIFT: assert property ($changed(readout_serial_out) && readout_trigger |-> since_q <= 5'h07)
      else $error("serial out moved without a shift clock rise");
   AST_DUMMY: assert property (smp && cnt_q >= 7'h01 && cnt_q <= 7'h05 |-> readout_serial_out)
      else $error("dummy bit low");
   AST_START: assert property (smp && cnt_q >= 7'h06 && cnt_q <= 7'h5a && fbit == 7'h00 |-> !readout_serial_out)
      else $error("start bit high");
   AST_FIRST_TWO: assert property (smp && cnt_q inside {7'h07, 7'h08} |-> readout_serial_out)
      else $error("first frame lead data bit low");
   AST_CHECK_BITS: assert property (smp && body && fbit > 7'h10 |-> readout_serial_out)
      else $error("check bit low");
   AST_LAST_SEVEN: assert property (smp && cnt_q >= 7'h53 && cnt_q < 7'h5a |-> readout_serial_out)
      else $error("last frame closing bit low");
   AST_RIP_LEN: assert property ($fell(read_in_progress) && readout_trigger |-> cnt_q == 7'h66)
      else $error("rip fell at wrong bit count");
   AST_ABORT: assert property ($fell(readout_trigger) && read_in_progress |-> ##[1:8] !read_in_progress)
      else $error("abort did not stop readback");
   AST_IDLE: assert property (!read_in_progress && $stable(read_in_progress) |-> readout_serial_out)
      else $error("serial out low while idle");
   cover property ($fell(read_in_progress) && readout_trigger);
   cover property ($fell(readout_trigger) && read_in_progress);
   cover property (smp && !readout_serial_out);
endmodule
`default_nettype wire

//--- verilog/crbk_ctl.sv
`timescale 1ns/1ps
`default_nettype none
module crbk_ctl (
   // Clock, reset, enable
   input  wire logic                        i_sys_clk,
   input  wire logic                        i_reset,
   input  wire logic                        i_ce,
   // Link
   crbk_link_if.ctl                         lnk,
   // Commands
   input  wire logic                        i_start,
   input  wire logic                        i_abort,
   output logic                             o_busy,
   // Word stream out
   output logic [crbk_pkg::WORD_W-1:0]      o_word,
   output logic                             o_word_last,
   output logic                             o_word_valid,
   input  wire logic                        i_word_ready
);
   typedef enum logic [1:0] {C_IDLE, C_RUN, C_WAIT, C_FLUSH} crbk_ctl_state_e;
   localparam int W  = crbk_pkg::WORD_W;
   localparam int BW = crbk_pkg::BIDX_W;

   crbk_ctl_state_e             state_q;
   logic [1:0]                  dat_s_q;
   logic [1:0]                  rip_s_q;
   logic [crbk_pkg::DIV_W-1:0]  div_q;
   logic                        sclk_q;
   logic                        trig_q;
   logic                        first_q;
   logic [BW-1:0]               bidx_q;
   logic [crbk_pkg::CNT_W-1:0]  off_q;
   logic [crbk_pkg::FIDX_W-1:0] fr_q;
   logic [W-1:0]                acc_q;
   logic [2:0]                  flush_q;
   logic                        out_v_q;
   logic [W:0]                  out_q;
   logic                        sp_v_q;
   logic [W:0]                  sp_q;

   wire            tick     = i_ce & (div_q == crbk_pkg::DIV_W'(crbk_pkg::CLK_HALF - 1));
   wire            in_frm   = (bidx_q >= BW'(crbk_pkg::DUMMY_BITS)) &&
                              (bidx_q < BW'(crbk_pkg::TOTAL_BITS - crbk_pkg::CRC_BITS - 1));
   wire            last_fr  = (fr_q == crbk_pkg::FIDX_W'(crbk_pkg::FRAMES - 1));
   wire            room     = last_fr ? ~out_v_q : ~(out_v_q & sp_v_q);
   // Stall only ahead of the first data bit, far from any start window
   wire            hold     = (state_q == C_RUN) && in_frm && (off_q == 5'd1) && !room;
   wire            do_rise  = tick & ~sclk_q & ~hold & (state_q != C_IDLE);
   wire            do_fall  = tick & sclk_q;
   wire            sample   = do_fall & ~first_q & (state_q == C_RUN);
   wire [W-1:0]    acc_d    = {acc_q[W-2:0], dat_s_q[1]};
   wire            push_d   = sample && in_frm && (off_q == 5'(crbk_pkg::DATA_BITS));
   wire            push_c   = sample && (bidx_q == BW'(crbk_pkg::TOTAL_BITS - 1));
   wire            push     = push_d | push_c;
   wire [W:0]      pw       = {push_c, push_c ? W'(acc_d[crbk_pkg::CRC_BITS-1:0]) : acc_d};
   wire            pop      = out_v_q & i_word_ready & i_ce;

   assign lnk.readout_trigger     = trig_q;
   assign lnk.readout_shift_clock = sclk_q;
   assign o_busy                  = (state_q != C_IDLE);
   assign o_word                  = out_q[W-1:0];
   assign o_word_last             = out_q[W];
   assign o_word_valid            = out_v_q;

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         dat_s_q <= '0;
         rip_s_q <= '0;
      end else if (i_ce) begin
         dat_s_q <= {dat_s_q[0], lnk.readout_serial_out};
         rip_s_q <= {rip_s_q[0], lnk.read_in_progress};
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         state_q <= C_IDLE;
         div_q   <= '0;
         sclk_q  <= 1'b0;
         trig_q  <= 1'b0;
         first_q <= 1'b1;
         bidx_q  <= '0;
         off_q   <= '0;
         fr_q    <= '0;
         acc_q   <= '0;
         flush_q <= '0;
      end else if (i_ce) begin
         div_q <= tick ? '0 : div_q + 1'b1;
         if (do_rise) begin
            sclk_q <= 1'b1;
         end else if (do_fall) begin
            sclk_q <= 1'b0;
         end
         case (state_q)
            C_IDLE: begin
               if (i_start) begin
                  trig_q  <= 1'b1;
                  first_q <= 1'b1;
                  bidx_q  <= '0;
                  off_q   <= 5'(crbk_pkg::FRAME_BITS - crbk_pkg::DUMMY_BITS);
                  fr_q    <= '1;
                  div_q   <= '0;
                  state_q <= C_RUN;
               end
            end
            C_RUN: begin
               if (i_abort) begin
                  trig_q  <= 1'b0;
                  flush_q <= 3'(crbk_pkg::REINIT_CLKS);
                  state_q <= C_FLUSH;
               end else if (do_fall) begin
                  first_q <= 1'b0;
                  if (sample) begin
                     acc_q  <= acc_d;
                     bidx_q <= bidx_q + 1'b1;
                     if (off_q == 5'(crbk_pkg::FRAME_BITS - 1)) begin
                        off_q <= '0;
                        fr_q  <= fr_q + 1'b1;
                     end else begin
                        off_q <= off_q + 1'b1;
                     end
                     if (push_c) begin
                        state_q <= C_WAIT;
                     end
                  end
               end
            end
            C_WAIT: begin
               if (do_fall && !rip_s_q[1]) begin
                  trig_q  <= 1'b0;
                  state_q <= C_IDLE;
               end
            end
            C_FLUSH: begin
               if (do_fall) begin
                  flush_q <= flush_q - 1'b1;
                  if (flush_q == 3'd1) begin
                     state_q <= C_IDLE;
                  end
               end
            end
            default: begin
               state_q <= C_IDLE;
            end
         endcase
      end
   end

   // Two-entry output buffer; head register drives the port
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         out_v_q <= 1'b0;
         out_q   <= '0;
         sp_v_q  <= 1'b0;
         sp_q    <= '0;
      end else if (i_ce) begin
         if (pop) begin
            if (sp_v_q) begin
               out_q  <= sp_q;
               sp_v_q <= push;
               sp_q   <= pw;
            end else begin
               out_v_q <= push;
               out_q   <= pw;
            end
         end else if (push) begin
            if (!out_v_q) begin
               out_v_q <= 1'b1;
               out_q   <= pw;
            end else begin
               sp_v_q <= 1'b1;
               sp_q   <= pw;
            end
         end
      end
   end
endmodule
`default_nettype wire

//--- verilog/crbk_dev.sv
// Notes on behaviour
// - Trigger rise arms; rip rises next clock
// - One new bit per later clock rise
// - No preamble or header in stream
// - Five high dummies, then low start
// - First frame's first two data high
// - Four high check bits end frames
// - Last frame's closing seven bits high
// - Final start, 11-bit signature, rip falls
// - Config plain, captured states inverted
// - Capture latches complements on trigger rise
// - Capture off returns loaded config
// - Writable tables read current contents
// - Abort: trigger fall stops and rearms
// - Controller gives re-init clocks after abort
// - Config or user clock, rising edges
// - Frame loaded in six cycles before start
// - Controller keeps clock steady near starts
// - Controller may stall clock elsewhere
// - Controller tracks position, no boundary pause
// - Readback never disturbs user logic
// - Refuse until three clocks after done
`timescale 1ns/1ps
`default_nettype none
module crbk_dev (
   // Clock, reset, enable
   input  wire logic                           i_sys_clk,
   input  wire logic                           i_reset,
   input  wire logic                           i_ce,
   // Link
   crbk_link_if.dev                            lnk,
   // Options fixed at configuration
   input  wire logic                           i_opt_capture,
   input  wire logic                           i_opt_abort,
   input  wire logic                           i_opt_user_clk,
   // Clock pins and done
   input  wire logic                           i_config_clock,
   input  wire logic                           i_done,
   // Configuration load
   input  wire logic                           i_cfg_we,
   input  wire logic [crbk_pkg::FIDX_W-1:0]    i_cfg_frame,
   input  wire logic [crbk_pkg::DATA_BITS-1:0] i_cfg_word,
   // Table memory write
   input  wire logic                           i_ram_we,
   input  wire logic [crbk_pkg::RAM_AW-1:0]    i_ram_addr,
   input  wire logic                           i_ram_data,
   // Captured user states
   input  wire logic [3:0]                     i_logic_cell_out,
   input  wire logic                           i_io_cell_out_ff,
   input  wire logic                           i_io_input_first,
   input  wire logic                           i_io_input_second,
   // Status
   output logic                                o_ready
);
   typedef enum logic [2:0] {
      S_IDLE, S_ARM, S_DUMMY, S_START, S_DATA, S_ERR, S_END, S_CRC
   } crbk_dev_state_e;

   // Frame geometry comes from the package, not from the stream itself
   localparam int D     = crbk_pkg::DATA_BITS;
   localparam int CNT_W = crbk_pkg::CNT_W;

   crbk_dev_state_e                state_q;
   logic [D-1:0]                   cfg_mem [crbk_pkg::FRAMES];
   logic [2:0]                     clk_cfg_s_q;
   logic [2:0]                     clk_lnk_s_q;
   logic [2:0]                     trig_s_q;
   logic                           clk_prev_q;
   logic [1:0]                     done_cnt_q;
   logic [crbk_pkg::CAP_BITS-1:0]  cap_q;
   logic                           cap_en_q;
   logic [crbk_pkg::CNT_W-1:0]     cnt_q;
   logic [crbk_pkg::FIDX_W-1:0]    fidx_q;
   logic [D-1:0]                   sh_q;
   logic [D-1:0]                   nxt_q;
   logic [10:0]                    crc_q;
   logic [10:0]                    crc_sh_q;
   logic                           out_q;
   logic                           rip_q;
   logic                           ready_q;

   // Clock selection after synchronising both pins
   wire                            clk_sel   = i_opt_user_clk ? clk_lnk_s_q[1]
                                                              : clk_cfg_s_q[1];
   wire                            clk_rise  = i_ce & clk_sel & ~clk_prev_q;
   wire                            trig_rise = i_ce & trig_s_q[1] & ~trig_s_q[2];
   wire                            trig_fall = i_ce & ~trig_s_q[1] & trig_s_q[2];
   wire                            abort     = i_opt_abort & trig_fall & (state_q != S_IDLE);
   wire                            is_last   = (fidx_q == crbk_pkg::FIDX_W'(crbk_pkg::FRAMES - 1));
   wire [crbk_pkg::FIDX_W-1:0]     nxt_idx   = (state_q == S_ARM) ? '0 : fidx_q + 1'b1;

   // Next frame word with overlays
   wire [D-1:0]                    raw_word  = cfg_mem[nxt_idx];
   wire                            cap_here  = cap_en_q &
                                               (nxt_idx == crbk_pkg::FIDX_W'(crbk_pkg::CAP_FRAME));
   wire [D-1:0]                    cap_mask  = D'({crbk_pkg::CAP_BITS{1'b1}}) << crbk_pkg::CAP_LSB;
   wire [D-1:0]                    cap_word  = D'(cap_q) << crbk_pkg::CAP_LSB;
   wire [D-1:0]                    w_cap     = cap_here ? ((raw_word & ~cap_mask) | cap_word)
                                                        : raw_word;
   wire [D-1:0]                    first_m   = {{crbk_pkg::FIRST_HIGH{1'b1}},
                                                {(D - crbk_pkg::FIRST_HIGH){1'b0}}};
   wire [D-1:0]                    last_m    = D'({crbk_pkg::LAST_DATA_HIGH{1'b1}});
   wire                            nxt_first = (nxt_idx == '0);
   wire                            nxt_last  = (nxt_idx == crbk_pkg::FIDX_W'(crbk_pkg::FRAMES - 1));
   wire [D-1:0]                    nxt_word  = w_cap | (nxt_first ? first_m : '0)
                                               | (nxt_last ? last_m : '0);

   // Signature over the data bits
   wire                            data_bit  = sh_q[D-1];
   wire                            crc_fb    = crc_q[10] ^ data_bit;
   wire [10:0]                     crc_d     = {crc_q[9:0], 1'b0} ^ (crc_fb ? crbk_pkg::CRC_POLY
                                                                            : 11'h000);

   assign lnk.readout_serial_out = out_q;
   assign lnk.read_in_progress   = rip_q;
   assign o_ready                = ready_q;

   // Memory written by loading and by user table writes only
   always_ff @(posedge i_sys_clk) begin
      if (i_ce) begin
         if (i_cfg_we) begin
            cfg_mem[i_cfg_frame] <= i_cfg_word;
         end else if (i_ram_we) begin
            cfg_mem[crbk_pkg::RAM_FRAME][i_ram_addr] <= i_ram_data;
         end
      end
   end

   // Pin synchronisers
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         clk_cfg_s_q <= '0;
         clk_lnk_s_q <= '0;
         trig_s_q    <= '0;
         clk_prev_q  <= 1'b0;
      end else if (i_ce) begin
         clk_cfg_s_q <= {clk_cfg_s_q[1:0], i_config_clock};
         clk_lnk_s_q <= {clk_lnk_s_q[1:0], lnk.readout_shift_clock};
         trig_s_q    <= {trig_s_q[1:0], lnk.readout_trigger};
         clk_prev_q  <= clk_sel;
      end
   end

   // Done qualification; a done drop clears it
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         done_cnt_q <= '0;
         ready_q    <= 1'b0;
      end else if (i_ce) begin
         if (!i_done) begin
            done_cnt_q <= '0;
            ready_q    <= 1'b0;
         end else if (clk_rise && done_cnt_q != 2'(crbk_pkg::DONE_CLKS)) begin
            done_cnt_q <= done_cnt_q + 1'b1;
         end
         if (i_done && done_cnt_q == 2'(crbk_pkg::DONE_CLKS)) begin
            ready_q <= 1'b1;
         end
      end
   end

   // Stream sequencer; only reads user state, never drives it
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         state_q  <= S_IDLE;
         cap_q    <= '0;
         cap_en_q <= 1'b0;
         cnt_q    <= '0;
         fidx_q   <= '0;
         sh_q     <= '0;
         nxt_q    <= '0;
         crc_q    <= crbk_pkg::CRC_INIT;
         crc_sh_q <= '0;
         out_q    <= 1'b1;
         rip_q    <= 1'b0;
      end else if (abort) begin
         state_q <= S_IDLE;
         rip_q   <= 1'b0;
         out_q   <= 1'b1;
      end else if (state_q == S_IDLE) begin
         if (trig_rise && ready_q) begin
            state_q  <= S_ARM;
            cap_en_q <= i_opt_capture;
            if (i_opt_capture) begin
               cap_q <= ~{i_logic_cell_out, i_io_cell_out_ff,
                          i_io_input_first, i_io_input_second};
            end
         end
      end else if (clk_rise) begin
         cnt_q <= cnt_q + 1'b1;
         case (state_q)
            S_ARM: begin
               rip_q   <= 1'b1;
               nxt_q   <= nxt_word;
               fidx_q  <= '0;
               crc_q   <= crbk_pkg::CRC_INIT;
               cnt_q   <= '0;
               state_q <= S_DUMMY;
            end
            S_DUMMY: begin
               out_q <= 1'b1;
               if (cnt_q == CNT_W'(crbk_pkg::DUMMY_BITS - 1)) begin
                  cnt_q   <= '0;
                  state_q <= S_START;
               end
            end
            S_START: begin
               out_q   <= 1'b0;
               sh_q    <= nxt_q;
               cnt_q   <= '0;
               state_q <= S_DATA;
            end
            S_DATA: begin
               out_q <= data_bit;
               sh_q  <= {sh_q[D-2:0], 1'b0};
               crc_q <= crc_d;
               if (cnt_q == CNT_W'(D + crbk_pkg::ERR_BITS - crbk_pkg::LOAD_WIN) && !is_last) begin
                  nxt_q <= nxt_word;
               end
               if (cnt_q == CNT_W'(D - 1)) begin
                  cnt_q   <= '0;
                  state_q <= S_ERR;
               end
            end
            S_ERR: begin
               out_q <= 1'b1;
               if (cnt_q == CNT_W'(crbk_pkg::ERR_BITS - 1)) begin
                  cnt_q   <= '0;
                  fidx_q  <= fidx_q + 1'b1;
                  state_q <= is_last ? S_END : S_START;
               end
            end
            S_END: begin
               out_q    <= 1'b0;
               crc_sh_q <= crc_q;
               cnt_q    <= '0;
               state_q  <= S_CRC;
            end
            S_CRC: begin
               out_q    <= crc_sh_q[10];
               crc_sh_q <= {crc_sh_q[9:0], 1'b0};
               if (cnt_q == CNT_W'(crbk_pkg::CRC_BITS)) begin
                  out_q   <= 1'b1;
                  rip_q   <= 1'b0;
                  state_q <= S_IDLE;
               end
            end
            default: begin
               state_q <= S_IDLE;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

//--- verilog/crbk_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface crbk_link_if;
   logic readout_trigger;
   logic readout_shift_clock;
   logic readout_serial_out;
   logic read_in_progress;
   modport dev (
      input  readout_trigger,
      input  readout_shift_clock,
      output readout_serial_out,
      output read_in_progress
   );
   modport ctl (
      output readout_trigger,
      output readout_shift_clock,
      input  readout_serial_out,
      input  read_in_progress
   );
endinterface
`default_nettype wire

//--- verilog/crbk_pkg.sv
package crbk_pkg;
   // Stream layout
   localparam int DUMMY_BITS      = 5;
   localparam int FIRST_HIGH      = 2;
   localparam int ERR_BITS        = 4;
   localparam int LAST_HIGH       = 7;
   localparam int LAST_DATA_HIGH  = LAST_HIGH - ERR_BITS;
   localparam int CRC_BITS        = 11;
   localparam int LOAD_WIN        = 6;
   localparam int DONE_CLKS       = 3;
   // Frame geometry, free implementation choice
   localparam int DATA_BITS       = 16;
   localparam int FRAMES          = 4;
   localparam int FIDX_W          = 2;
   localparam int CNT_W           = 5;
   localparam int FRAME_BITS      = 1 + DATA_BITS + ERR_BITS;
   localparam int TOTAL_BITS      = DUMMY_BITS + FRAMES * FRAME_BITS + 1 + CRC_BITS;
   localparam int BIDX_W          = 7;
   // Capture overlay: four cell outputs, io output flop, two io inputs
   localparam int CAP_BITS        = 7;
   localparam int CAP_FRAME       = 1;
   localparam int CAP_LSB         = 8;
   // Function tables usable as writable memory
   localparam int RAM_FRAME       = 2;
   localparam int RAM_AW          = 3;
   // Signature
   localparam logic [10:0] CRC_POLY = 11'h005;
   localparam logic [10:0] CRC_INIT = 11'h000;
   // Controller shift clock: half period in system clocks
   localparam int CLK_HALF        = 10;
   localparam int DIV_W           = 4;
   localparam int REINIT_CLKS     = FRAMES;
   localparam int WORD_W          = DATA_BITS;
endpackage
